// ---- gpio_port_pkg.sv ----
// Package with register map, reset values and pad carrier for the debug-shared port
package gpio_port_pkg;

    localparam int PORT_WIDTH = 8;
    localparam int ADDR_WIDTH = 12;

    // Register byte offsets from the port base
    localparam logic [11:0] OFS_PIN_DATA = 12'h000;
    localparam logic [11:0] OFS_OUTPUT_ENABLE_CTRL = 12'h004;
    localparam logic [11:0] OFS_ALT_FUNCTION_SELECT = 12'h008;
    localparam logic [11:0] OFS_OPEN_DRAIN_CTRL = 12'h028;
    localparam logic [11:0] OFS_PULL_UP_CTRL = 12'h02C;
    localparam logic [11:0] OFS_PULL_DOWN_CTRL = 12'h030;
    localparam logic [11:0] OFS_INPUT_ENABLE_CTRL = 12'h038;

    // Debug pin positions
    localparam int BIT_TCK = 3;
    localparam int BIT_TMS = 4;
    localparam int BIT_TDO = 5;
    localparam int BIT_TDI = 6;
    localparam int BIT_TRST = 7;

    // Reset values of each control register
    localparam logic [7:0] RST_PIN_DATA = 8'h00;
    localparam logic [7:0] RST_OUTPUT_ENABLE = 8'h30;
    localparam logic [7:0] RST_ALT_FUNCTION = 8'hF8;
    localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
    localparam logic [7:0] RST_PULL_UP = 8'hD0;
    localparam logic [7:0] RST_PULL_DOWN = 8'h08;
    localparam logic [7:0] RST_INPUT_ENABLE = 8'hD8;

    // Pad controls for all eight pins
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
        logic [7:0] pull_up;
        logic [7:0] pull_down;
        logic [7:0] in_en;
    } pad_ctrl_s;

    // Debug core side of the shared pins
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } debug_drive_s;

endpackage

// ---- debug_shared_gpio_port.sv ----
// Eight-bit general-purpose port with debug sharing and an APB register slave
//
// Contract
// - Eight bits, direction set per bit
// - Bit 7 resets to TRST, input, pull-up
// - Bit 6 resets to TDI, input, pull-up
// - Bit 3 resets to debug clock, input, pull-down
// - Bit 4 resets to TMS/SWDIO, input, output, pull-up
// - Bit 5 resets to TDO/SWV, output enabled
// - Other bits reset to plain port, all disabled
// - Function bit 1 alternate, 0 port
// - Debug bits 4/5 keep driving in deep stop
// - Data register bits 7-0, upper read zero
// - Output-control bit 1 enables pin driver
// - Function register decoded at 0x008
// - Open-drain register decoded at 0x028
// - Pull-up 0x02C, pull-down 0x030 decoded
// - Input-enable register decoded at 0x038
// - Open-drain bit 0 push-pull, 1 open-drain
module debug_shared_gpio_port
    import gpio_port_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_in,
    output pad_ctrl_s pad,
    input wire debug_drive_s debug_drive,
    output logic [7:0] debug_in,
    input wire logic deep_stop,
    input wire logic standby_out_keep
);

    // Control registers
    logic [7:0] pin_data;
    logic [7:0] output_enable_ctrl;
    logic [7:0] alt_function_select;
    logic [7:0] open_drain_ctrl;
    logic [7:0] pull_up_ctrl;
    logic [7:0] pull_down_ctrl;
    logic [7:0] input_enable_ctrl;
    logic [7:0] pin_sample;

    // Address decode
    // function register decode
    wire hit_data = (paddr == OFS_PIN_DATA);
    wire hit_oe = (paddr == OFS_OUTPUT_ENABLE_CTRL);
    wire hit_func = (paddr == OFS_ALT_FUNCTION_SELECT);
    wire hit_od = (paddr == OFS_OPEN_DRAIN_CTRL);
    wire hit_pu = (paddr == OFS_PULL_UP_CTRL);
    wire hit_pd = (paddr == OFS_PULL_DOWN_CTRL);
    wire hit_ie = (paddr == OFS_INPUT_ENABLE_CTRL);
    wire hit_any = hit_data | hit_oe | hit_func | hit_od | hit_pu | hit_pd | hit_ie;

    // Bus phases; one wait state so the read mux settles before prdata is taken
    wire access = psel & penable;
    wire next_pready = access & ~pready;
    wire wr_commit = access & pready & pwrite & hit_any & pstrb[0];

    // Data read view: enabled inputs show the sampled pin, outputs the written latch
    // data read mux
    wire [7:0] data_view = (output_enable_ctrl & pin_data)
        | (~output_enable_ctrl & input_enable_ctrl & pin_sample);

    // Read data selection, upper bits always zero
    // upper bits zero
    wire [7:0] rd_byte = ({8{hit_data}} & data_view)
        | ({8{hit_oe}} & output_enable_ctrl)
        | ({8{hit_func}} & alt_function_select)
        | ({8{hit_od}} & open_drain_ctrl)
        | ({8{hit_pu}} & pull_up_ctrl)
        | ({8{hit_pd}} & pull_down_ctrl)
        | ({8{hit_ie}} & input_enable_ctrl);
    wire [31:0] next_prdata = {24'h000000, rd_byte};

    // Answer flops; an unmapped or reserved offset answers with an error and zero data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= next_pready;
            prdata <= (next_pready & ~pwrite) ? next_prdata : 32'h00000000;
            pslverr <= next_pready & ~hit_any;
        end
    end

    // Register writes, taken on the edge that sees pready high
    // reset to TRST setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_data <= RST_PIN_DATA;
            output_enable_ctrl <= RST_OUTPUT_ENABLE;
            alt_function_select <= RST_ALT_FUNCTION;
            open_drain_ctrl <= RST_OPEN_DRAIN;
            pull_up_ctrl <= RST_PULL_UP;
            pull_down_ctrl <= RST_PULL_DOWN;
            input_enable_ctrl <= RST_INPUT_ENABLE;
        end
        else if (wr_commit)
        begin
            if (hit_data)
                pin_data <= pwdata[7:0];
            if (hit_oe)
                output_enable_ctrl <= pwdata[7:0];
            if (hit_func)
                alt_function_select <= pwdata[7:0];
            if (hit_od)
                open_drain_ctrl <= pwdata[7:0];
            if (hit_pu)
                pull_up_ctrl <= pwdata[7:0];
            if (hit_pd)
                pull_down_ctrl <= pwdata[7:0];
            if (hit_ie)
                input_enable_ctrl <= pwdata[7:0];
        end
    end

    // Per-pin pad logic; each bit chooses direction on its own
    // per-bit direction
    pad_ctrl_s next_pad;
    logic [7:0] next_debug_in;
    logic [7:0] stop_hold;
    genvar i;
    generate
        for (i = 0; i < PORT_WIDTH; i++)
        begin : g_pin
            wire alt = alt_function_select[i];
            wire value = alt ? debug_drive.out[i] : pin_data[i];
            wire want_drive = output_enable_ctrl[i] & (~alt | debug_drive.oe[i]);
            wire stop_exempt = alt & ((i == BIT_TMS) || (i == BIT_TDO));
            assign stop_hold[i] = ~deep_stop | standby_out_keep | stop_exempt;
            wire drive = want_drive & stop_hold[i] & (~open_drain_ctrl[i] | ~value);
            assign next_pad.out[i] = value;
            assign next_pad.oe_n[i] = ~drive;
            assign next_pad.pull_up[i] = pull_up_ctrl[i];
            assign next_pad.pull_down[i] = pull_down_ctrl[i];
            assign next_pad.in_en[i] = input_enable_ctrl[i];
            // Disabled input buffer reads low, so the debug core sees no float
            assign next_debug_in[i] = alt & input_enable_ctrl[i] & pin_in[i];
        end
    endgenerate

    // Pad and input flops; outputs come straight from here
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad.out <= 8'h00;
            pad.oe_n <= 8'hFF;
            pad.pull_up <= RST_PULL_UP;
            pad.pull_down <= RST_PULL_DOWN;
            pad.in_en <= RST_INPUT_ENABLE;
            debug_in <= 8'h00;
            pin_sample <= 8'h00;
        end
        else
        begin
            pad <= next_pad;
            debug_in <= next_debug_in;
            pin_sample <= pin_in;
        end
    end

    // Checks on the design's own behaviour
    logic first_cycle;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            first_cycle <= 1'b1;
        else
            first_cycle <= 1'b0;
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_oe_write;
        access & pready & pwrite & hit_oe & pstrb[0];
    endsequence

    sequence s_read_setup;
        psel & ~penable & ~pwrite;
    endsequence

    property p_rst_trst;
        first_cycle |-> alt_function_select[BIT_TRST] & input_enable_ctrl[BIT_TRST]
            & pull_up_ctrl[BIT_TRST];
    endproperty
    a_rst_trst: assert property (p_rst_trst) else $error("bit 7 not TRST after reset");

    property p_rst_tdi;
        first_cycle |-> alt_function_select[BIT_TDI] & input_enable_ctrl[BIT_TDI]
            & pull_up_ctrl[BIT_TDI] & pad.pull_up[BIT_TDI];
    endproperty
    a_rst_tdi: assert property (p_rst_tdi) else $error("bit 6 not TDI after reset");

    property p_rst_tck;
        first_cycle |-> alt_function_select[BIT_TCK] & input_enable_ctrl[BIT_TCK]
            & pull_down_ctrl[BIT_TCK] & ~pull_up_ctrl[BIT_TCK];
    endproperty
    a_rst_tck: assert property (p_rst_tck) else $error("bit 3 not debug clock");

    property p_rst_tms;
        first_cycle |-> alt_function_select[BIT_TMS] & input_enable_ctrl[BIT_TMS]
            & output_enable_ctrl[BIT_TMS] & pull_up_ctrl[BIT_TMS];
    endproperty
    a_rst_tms: assert property (p_rst_tms) else $error("bit 4 not TMS after reset");

    property p_rst_tdo;
        first_cycle |-> alt_function_select[BIT_TDO] & output_enable_ctrl[BIT_TDO];
    endproperty
    a_rst_tdo: assert property (p_rst_tdo) else $error("bit 5 not TDO after reset");

    property p_rst_gp;
        first_cycle |-> (alt_function_select[2:0] == 3'h0) && (input_enable_ctrl[2:0] == 3'h0)
            && (output_enable_ctrl[2:0] == 3'h0) && (pull_up_ctrl[2:0] == 3'h0);
    endproperty
    a_rst_gp: assert property (p_rst_gp) else $error("plain bits not reset idle");

    property p_func_mux;
        alt_function_select[BIT_TDO] |=> pad.out[BIT_TDO] == $past(debug_drive.out[BIT_TDO]);
    endproperty
    a_func_mux: assert property (p_func_mux) else $error("alternate value not routed");

    property p_stop_keep;
        deep_stop & ~standby_out_keep & alt_function_select[BIT_TDO]
            & output_enable_ctrl[BIT_TDO] & debug_drive.oe[BIT_TDO] & ~open_drain_ctrl[BIT_TDO]
            |=> !pad.oe_n[BIT_TDO];
    endproperty
    a_stop_keep: assert property (p_stop_keep) else $error("TDO dropped in deep stop");

    property p_read_upper;
        s_read_setup ##2 (access & pready) |-> prdata[31:8] == 24'h000000;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("upper read bits not zero");

    property p_oe_write;
        s_oe_write |=> output_enable_ctrl == $past(pwdata[7:0]) ##1
            pad.oe_n[7:0] == (pad.oe_n[7:0] | ~$past(output_enable_ctrl, 1));
    endproperty
    a_oe_write: assert property (p_oe_write) else $error("output control write lost");

    property p_od_high;
        (!pad.oe_n[0] && pad.out[0]) |-> !$past(open_drain_ctrl[0]);
    endproperty
    a_od_high: assert property (p_od_high) else $error("open-drain pin drove high");

    property p_unmapped;
        (access & ~pready & ~hit_any) |=> pready & pslverr ##1 !pready;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("reserved offset not refused");

    // Read request edge; the answer shows one edge later
    sequence s_read_ask;
        access & ~pready & ~pwrite;
    endsequence

    // Pad mirrors of the debug pull setup, straight after reset
    property p_pad_trst;
        first_cycle |-> pad.pull_up[BIT_TRST] & pad.in_en[BIT_TRST] & ~pad.pull_down[BIT_TRST];
    endproperty
    a_pad_trst: assert property (p_pad_trst) else $error("bit 7 pad not pulled up");

    property p_pad_tck;
        first_cycle |-> pad.pull_down[BIT_TCK] & pad.in_en[BIT_TCK]
            & ~pad.pull_up[BIT_TCK];
    endproperty
    a_pad_tck: assert property (p_pad_tck) else $error("bit 3 pad not pulled down");

    property p_debug_in_trst;
        alt_function_select[BIT_TRST] & input_enable_ctrl[BIT_TRST]
            |=> debug_in[BIT_TRST] == $past(pin_in[BIT_TRST]);
    endproperty
    a_debug_in_trst: assert property (p_debug_in_trst) else $error("reset pin not routed");

    // Port direction per bit; a disabled driver must release the pin
    property p_dir_off;
        ~alt_function_select[0] & ~output_enable_ctrl[0] |=> pad.oe_n[0];
    endproperty
    a_dir_off: assert property (p_dir_off) else $error("input bit still driven");

    property p_dir_on;
        ~alt_function_select[1] & output_enable_ctrl[1] & ~open_drain_ctrl[1] & ~deep_stop
            |=> !pad.oe_n[1];
    endproperty
    a_dir_on: assert property (p_dir_on) else $error("output bit not driven");

    property p_port_mux;
        ~alt_function_select[2] |=> pad.out[2] == $past(pin_data[2]);
    endproperty
    a_port_mux: assert property (p_port_mux) else $error("port value not routed");

    // Deep stop without standby_out_keep: only the two debug outputs keep their drivers
    property p_stop_keep_tms;
        deep_stop & ~standby_out_keep & alt_function_select[BIT_TMS]
            & output_enable_ctrl[BIT_TMS] & debug_drive.oe[BIT_TMS] & ~open_drain_ctrl[BIT_TMS]
            |=> !pad.oe_n[BIT_TMS];
    endproperty
    a_stop_keep_tms: assert property (p_stop_keep_tms) else $error("TMS dropped in deep stop");

    property p_stop_off;
        deep_stop & ~standby_out_keep & ~alt_function_select[0] |=> pad.oe_n[0];
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("port bit driven in deep stop");

    // Read-back of the output, function, open-drain, pull-up and input-enable registers through the decode
    property p_oe_read;
        s_read_ask ##0 hit_oe |=> prdata == {24'h000000, $past(output_enable_ctrl)};
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("output control read wrong");

    property p_func_read;
        s_read_ask ##0 hit_func |=> prdata == {24'h000000, $past(alt_function_select)};
    endproperty
    a_func_read: assert property (p_func_read) else $error("function read wrong");

    property p_od_read;
        s_read_ask ##0 hit_od |=> prdata == {24'h000000, $past(open_drain_ctrl)};
    endproperty
    a_od_read: assert property (p_od_read) else $error("open-drain read wrong");

    property p_pu_read;
        s_read_ask ##0 hit_pu |=> prdata == {24'h000000, $past(pull_up_ctrl)};
    endproperty
    a_pu_read: assert property (p_pu_read) else $error("pull-up read wrong");

    property p_ie_read;
        s_read_ask ##0 hit_ie |=> prdata == {24'h000000, $past(input_enable_ctrl)};
    endproperty
    a_ie_read: assert property (p_ie_read) else $error("input enable read wrong");

    // Data read: outputs give the latch, enabled inputs the sampled pin
    property p_data_out;
        s_read_ask ##0 (hit_data & output_enable_ctrl[0])
            |=> prdata[0] == $past(pin_data[0]);
    endproperty
    a_data_out: assert property (p_data_out) else $error("output bit read not latch");

    property p_data_in;
        s_read_ask ##0 (hit_data & ~output_enable_ctrl[7] & input_enable_ctrl[7])
            |=> prdata[7] == $past(pin_sample[7]);
    endproperty
    a_data_in: assert property (p_data_in) else $error("input bit read not pin");

    // Masked or unmapped writes must leave every register alone
    property p_write_ignored;
        access & pready & pwrite & (~pstrb[0] | ~hit_any)
            |=> $stable({pin_data, output_enable_ctrl, alt_function_select, open_drain_ctrl,
                pull_up_ctrl, pull_down_ctrl, input_enable_ctrl});
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("ignored write landed");

endmodule

// ---- board_pins.sv ----
// Board-side pin model: resolves device drive, probe drive and pulls
module board_pins
    import gpio_port_pkg::*;
(
    input wire logic pclk,
    input wire pad_ctrl_s pad,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] last = 8'h00;

    // Device driver wins; a floating pin wobbles so no stale level passes
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!pad.oe_n[i])
                pin_in[i] = pad.out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pad.pull_up[i])
                pin_in[i] = 1'b1;
            else if (pad.pull_down[i])
                pin_in[i] = 1'b0;
            else
                pin_in[i] = ~last[i];
        end
    end

    // Remember last level for the floating pattern
    always @(posedge pclk)
        last <= pin_in;
endmodule

// ---- debug_shared_gpio_port_bench.sv ----
// Register-level bench for the debug-shared port
`define CHK(g, x) \
    begin \
        checked++; \
        if ((g) !== (x)) \
        begin \
            err_count++; \
            $display("BAD t=%0t got %h exp %h", $time, (g), (x)); \
        end \
    end
module debug_shared_gpio_port_bench
    import gpio_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, deep_stop, standby_out_keep;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [7:0] pin_in, debug_in, ext_en, ext_val;
    pad_ctrl_s pad;
    debug_drive_s debug_drive;
    int err_count = 0;
    int checked = 0;
    logic [11:0] ra[7] = '{OFS_PIN_DATA, OFS_OUTPUT_ENABLE_CTRL, OFS_ALT_FUNCTION_SELECT,
        OFS_OPEN_DRAIN_CTRL, OFS_PULL_UP_CTRL, OFS_PULL_DOWN_CTRL, OFS_INPUT_ENABLE_CTRL};
    logic [7:0] rv[7] = '{8'hC0, 8'h30, 8'hF8, 8'h00, 8'hD0, 8'h08, 8'hD8};
    // refused offsets lie past the map; the reserved gaps stay untouched
    logic [11:0] bad[4] = '{12'h03C, 12'h040, 12'h100, 12'hFFC};

    debug_shared_gpio_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pad(pad),
        .debug_drive(debug_drive), .debug_in(debug_in), .deep_stop(deep_stop),
        .standby_out_keep(standby_out_keep));
    board_pins pins (.pclk(pclk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val),
        .pin_in(pin_in));

    // Free-running 200 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic give_verdict;
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            err_count++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, s, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic xe = 1'b0);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, 4'hF, r, e);
        `CHK(r, {24'h0, x})
        `CHK(e, xe)
    endtask

    // Pad outputs lag their cause by one cycle
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask

    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, deep_stop, standby_out_keep} = 6'h0;
        {paddr, pwdata, pstrb, debug_drive, ext_en, ext_val} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        `CHK({pad.pull_up, pad.pull_down, pad.in_en}, 24'hD0_08D8)
        `CHK(debug_in, 8'hD0)
        for (int i = 0; i < 7; i++)
            rd(ra[i], rv[i]);
        @(posedge pclk);
        debug_drive <= '{out: 8'h20, oe: 8'h30};
        deep_stop <= 1'b1;
        settle();
        `CHK({pad.oe_n, pad.out[5:4]}, 10'h33E)
        wr(OFS_ALT_FUNCTION_SELECT, 32'h0);
        wr(OFS_OUTPUT_ENABLE_CTRL, 32'hFFFF_FF0F);
        wr(OFS_PIN_DATA, 32'hFFFF_FF05);
        settle();
        `CHK(pad.oe_n, 8'hFF)
        @(posedge pclk);
        standby_out_keep <= 1'b1;
        settle();
        `CHK({pad.oe_n, pad.out[3:0]}, 12'hF05)
        @(posedge pclk);
        {deep_stop, standby_out_keep} <= 2'b00;
        wr(OFS_OPEN_DRAIN_CTRL, 32'h3);
        settle();
        `CHK(pad.oe_n, 8'hF1)
        wr(OFS_INPUT_ENABLE_CTRL, 32'hF0);
        {ext_en, ext_val} <= 16'hF0A0;
        settle();
        `CHK(pad.in_en, 8'hF0)
        rd(OFS_PIN_DATA, 8'hA5);
        wr(OFS_PULL_UP_CTRL, 32'h55, 4'h1);
        wr(OFS_PULL_DOWN_CTRL, 32'hAA);
        wr(OFS_PULL_UP_CTRL, 32'hFF, 4'h0);
        settle();
        `CHK({pad.pull_up, pad.pull_down}, 16'h55AA)
        rd(OFS_PULL_UP_CTRL, 8'h55);
        for (int i = 0; i < 4; i++)
        begin
            wr(bad[i], 32'hFF);
            rd(bad[i], 8'h00, 1'b1);
        end
        rd(OFS_OPEN_DRAIN_CTRL, 8'h03);
        give_verdict();
    end
endmodule
